// >>> logic/bus_address_and_vout_reset_config.sv
`timescale 1ns/1ns
module bus_address_and_vout_reset_config
  import addr_reset_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire bus_req_s req,
  input wire logic restore,
  input wire logic [15:0] stored_cfg,
  input wire logic [6:0] stored_addr,
  input wire logic [6:0] strap_addr,
  input wire logic strap_external_divider_select,
  input wire logic strap_primary,
  input wire logic output_reset_pin,
  input wire logic [3:0] scale_mantissa,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [6:0] respond_addr,
  output logic [6:0] strap_base,
  output logic [15:0] save_cfg,
  output logic [15:0] save_addr,
  output logic save_strobe,
  output logic boot_transition,
  output cfg_out_s cfg_out
);
  // pin synchroniser
  logic pin_s1;
  logic pin_s2;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end
    else
    begin
      pin_s1 <= output_reset_pin;
      pin_s2 <= pin_s1;
    end
  end

  // register state
  logic [3:0] cfg;
  logic [6:0] common_addr;
  logic [6:0] unique_addr;
  logic [3:0] next_cfg;
  logic [6:0] next_common_addr;
  logic [6:0] next_unique_addr;
  logic [15:0] next_rd_data;
  logic next_rd_valid;
  logic [6:0] next_respond_addr;
  logic [6:0] next_strap_base;
  logic next_save_strobe;
  logic next_boot_transition;
  cfg_out_s next_cfg_out;
  logic [6:0] shifted;
  logic [7:0] top_sum;

  always_comb
  begin
    next_cfg = cfg;
    next_common_addr = common_addr;
    next_unique_addr = unique_addr;
    next_respond_addr = respond_addr;
    next_strap_base = strap_base;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_save_strobe = 1'b0;
    shifted = stored_addr;
    top_sum = {1'b0, stored_addr} + {1'b0, STRAP_SPAN};
    if (restore)
    begin
      // address only takes effect on supply restore
      next_cfg = stored_cfg[3:0];  // see [RULE_07]
      next_common_addr = stored_addr;  // see [RULE_11]
      next_unique_addr = strap_primary ? stored_addr : stored_cfg[14:8];  // see [RULE_12]
      next_respond_addr = stored_addr;  // see [RULE_07]
      // strap range moves by the stored shift, clamped at the top
      shifted = top_sum[7] ? ADDR_CLAMP_BASE : stored_addr;  // see [RULE_08] see [RULE_09]
      next_strap_base = shifted;
    end
    else if (req.wr)
    begin
      if (req.cmd == CMD_RESET_PIN_OV)
        next_cfg = req.data[3:0] & CFG_WRITABLE_MASK[3:0];  // see [RULE_01] see [RULE_14]
      else if (req.cmd == CMD_BUS_ADDRESS)
      begin
        next_common_addr = req.data[14:8];  // see [RULE_10] see [RULE_13]
        next_unique_addr = strap_primary ? req.data[14:8] : req.data[6:0];  // see [RULE_12]
      end
      else if (req.cmd == CMD_STORE_ALL)
        next_save_strobe = 1'b1;  // see [RULE_07]
    end
    else if (req.rd)
    begin
      next_rd_valid = 1'b1;
      if (req.cmd == CMD_BUS_ADDRESS)
        next_rd_data = {1'b0, common_addr, 1'b0, unique_addr} & ADDR_WRITABLE_MASK;  // see [RULE_10]
      else if (req.cmd == CMD_RESET_PIN_OV)
        next_rd_data = {11'h000, strap_external_divider_select, cfg};  // see [RULE_01] see [RULE_14]
      else
        next_rd_data = 16'h0000;
    end
  end

  // derived thresholds and the boot transition request
  always_comb
  begin
    next_cfg_out.reset_high_mv = next_cfg[BIT_HI_TH] ? RST_HI_HIGH_SEL : RST_HI_LOW_SEL;  // see [RULE_02]
    next_cfg_out.reset_low_mv = next_cfg[BIT_HI_TH] ? RST_LO_HIGH_SEL : RST_LO_LOW_SEL;  // see [RULE_02]
    unique case (scale_mantissa)  // see [RULE_05]
      MANT_8: next_cfg_out.ov_mv = next_cfg[BIT_OV_SEL] ? OV_1_M8 : OV_0_M8;
      MANT_4: next_cfg_out.ov_mv = next_cfg[BIT_OV_SEL] ? OV_1_M4 : OV_0_M4;
      MANT_2: next_cfg_out.ov_mv = next_cfg[BIT_OV_SEL] ? OV_1_M2 : OV_0_M2;
      MANT_1: next_cfg_out.ov_mv = next_cfg[BIT_OV_SEL] ? OV_1_M1 : OV_0_M1;
      default: next_cfg_out.ov_mv = next_cfg[BIT_OV_SEL] ? OV_1_M8 : OV_0_M8;
    endcase
    next_cfg_out.ov_enable = ~next_cfg[BIT_OV_DIS];  // see [RULE_06]
    next_cfg_out.reset_enable = next_cfg[BIT_RST_EN];
    // level request, so enabling while low starts at once
    next_boot_transition = next_cfg[BIT_RST_EN] & ~pin_s2;  // see [RULE_03] see [RULE_04]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg <= 4'h0;
      common_addr <= 7'h00;
      unique_addr <= 7'h00;
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      respond_addr <= 7'h00;
      strap_base <= 7'h00;
      save_strobe <= 1'b0;
      boot_transition <= 1'b0;
      cfg_out <= '0;
    end
    else
    begin
      cfg <= next_cfg;
      common_addr <= next_common_addr;
      unique_addr <= next_unique_addr;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      respond_addr <= next_respond_addr;
      strap_base <= next_strap_base;
      save_strobe <= next_save_strobe;
      boot_transition <= next_boot_transition;
      cfg_out <= next_cfg_out;
    end
  end

  // save image of current settings
  assign save_cfg = {1'b0, unique_addr, 4'h0, cfg};
  assign save_addr = {1'b0, common_addr, 1'b0, unique_addr};

  // strap range follows the stored address when no clamp is needed
  strap_shift_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_08]
    (restore && stored_addr <= ADDR_CLAMP_BASE) |=> strap_base == $past(stored_addr))
    else $error("strap range not shifted");

  external_divider_select_read_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_01]
    (req.rd && !req.wr && !restore && req.cmd == CMD_RESET_PIN_OV)
      |=> rd_data[BIT_EXTERNAL_DIVIDER_SELECT] == $past(strap_external_divider_select))
    else $error("divider bit not strapped value");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_10]
    rd_valid |-> (rd_data[15] == 1'b0 && rd_data[7] == 1'b0))
    else $error("reserved bit read nonzero");
  boot_start_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_04]
    !pin_s2 |=> (boot_transition == cfg[BIT_RST_EN]))
    else $error("boot transition missed");
  boot_ignore_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_03]
    boot_transition |-> cfg[BIT_RST_EN])
    else $error("transition while disabled");
  pin_idle_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_03]
    pin_s2 |=> !boot_transition)
    else $error("transition while pin high");
  ov_polarity_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_06]
    nrst |=> (cfg_out.ov_enable == ~cfg[BIT_OV_DIS]))
    else $error("ov enable polarity wrong");
  reset_thresh_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_02]
    nrst |=> (cfg_out.reset_high_mv == (cfg[BIT_HI_TH] ? RST_HI_HIGH_SEL : RST_HI_LOW_SEL)))
    else $error("reset threshold wrong");
  addr_hold_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_07]
    (!restore) |=> respond_addr == $past(respond_addr))
    else $error("address moved without restore");
  restore_addr_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_11]
    restore |=> (respond_addr == common_addr))
    else $error("shared field differs from address");
  clamp_range_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_09]
    restore |=> ({1'b0, strap_base} + {1'b0, STRAP_SPAN}) <= {1'b0, ADDR_TOP})
    else $error("strap range over top");
  primary_mirror_a: assert property (@(posedge clk) disable iff (!nrst)  // see [RULE_12]
    (strap_primary && (restore || (req.wr && req.cmd == CMD_BUS_ADDRESS)))
      |=> unique_addr == common_addr)
    else $error("secondary not mirrored");
endmodule // bus_address_and_vout_reset_config

// >>> logic/addr_reset_pkg.sv
// Operation
// [RULE_01] divider bit follows strap, writes not stored
// [RULE_02] threshold select picks 0.6/0.5 or 1.1/0.9
// [RULE_03] reset pin low moves target to boot voltage
// [RULE_04] enabling while pin low starts transition now
// [RULE_05] overvoltage threshold from select and mantissa
// [RULE_06] fixed overvoltage control bit is inverted enable
// [RULE_07] new address needs store then supply reset
// [RULE_08] stored change shifts all strap addresses
// [RULE_09] clamp strap range to 70h-7Fh on overflow
// [RULE_10] shared address 14:8, secondary 6:0, 15/7 zero
// [RULE_11] shared field reads the responding address; after a bus write it reads the written value until the next restore
// [RULE_12] primary device mirrors shared into secondary
// [RULE_13] address register is word command D3h
// [RULE_14] reserved read-only bits drop writes, read zero
package addr_reset_pkg;
  localparam logic [7:0] CMD_BUS_ADDRESS = 8'hd3;
  localparam logic [7:0] CMD_RESET_PIN_OV = 8'hd2;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam int BIT_EXTERNAL_DIVIDER_SELECT = 4;
  localparam int BIT_HI_TH = 3;
  localparam int BIT_RST_EN = 2;
  localparam int BIT_OV_SEL = 1;
  localparam int BIT_OV_DIS = 0;
  localparam logic [15:0] CFG_WRITABLE_MASK = 16'h000f;
  localparam logic [15:0] ADDR_WRITABLE_MASK = 16'h7f7f;
  localparam logic [6:0] ADDR_TOP = 7'h7f;
  localparam logic [6:0] ADDR_CLAMP_BASE = 7'h70;
  localparam logic [6:0] STRAP_SPAN = 7'h0f;
  // thresholds in millivolts
  localparam logic [12:0] RST_HI_LOW_SEL = 13'h0258;
  localparam logic [12:0] RST_LO_LOW_SEL = 13'h01f4;
  localparam logic [12:0] RST_HI_HIGH_SEL = 13'h044c;
  localparam logic [12:0] RST_LO_HIGH_SEL = 13'h0384;
  localparam logic [3:0] MANT_8 = 4'h8;
  localparam logic [3:0] MANT_4 = 4'h4;
  localparam logic [3:0] MANT_2 = 4'h2;
  localparam logic [3:0] MANT_1 = 4'h1;
  localparam logic [12:0] OV_0_M8 = 13'h02ee;
  localparam logic [12:0] OV_0_M4 = 13'h05dc;
  localparam logic [12:0] OV_0_M2 = 13'h0bb8;
  localparam logic [12:0] OV_0_M1 = 13'h12c0;
  localparam logic [12:0] OV_1_M8 = 13'h0384;
  localparam logic [12:0] OV_1_M4 = 13'h0708;
  localparam logic [12:0] OV_1_M2 = 13'h0e10;
  localparam logic [12:0] OV_1_M1 = 13'h1770;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } bus_req_s;
  typedef struct packed {
    logic [12:0] reset_high_mv;
    logic [12:0] reset_low_mv;
    logic [12:0] ov_mv;
    logic ov_enable;
    logic reset_enable;
  } cfg_out_s;
endpackage

// >>> testbench/host_model.sv
`timescale 1ns/1ns
module host_model
  import addr_reset_pkg::*;
(
  input wire logic clk,
  output bus_req_s req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial req = '0;
  // word write, one request cycle, then idle lines show junk
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, cmd: cmd, data: data};
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, data: ~data};
  endtask
  // word read, data taken while valid stands
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = '0;
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, cmd: cmd, data: 16'h5555};
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, data: 16'haaaa};
    repeat (4)
    begin
      #1;
      if (!ok && rd_valid === 1'b1)
      begin
        ok = 1'b1;
        data = rd_data;
      end
      if (!ok)
        @(posedge clk);
    end
  endtask
endmodule // host_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import addr_reset_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [3:0] m;
    logic [12:0] ov;
  } row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic restore = 1'b0;
  logic [15:0] stored_cfg = 16'h0000;
  logic [6:0] stored_addr = 7'h00;
  logic external_divider_select = 1'b1;
  logic prim = 1'b0;
  logic pin = 1'b1;
  logic [3:0] mant = 4'h8;
  logic [15:0] rd_data, save_cfg, save_addr, d;
  logic rd_valid, save_strobe, boot, ok;
  logic [6:0] respond_addr, strap_base;
  bus_req_s req;
  cfg_out_s co;
  int n_errors = 0;
  int num_checks = 0;
  row_s rows [9] = '{'{16'h0000, MANT_8, OV_0_M8}, '{16'hfff0, MANT_4, OV_0_M4},
    '{16'h0002, 4'h3, OV_1_M8},
    '{16'h0008, MANT_2, OV_0_M2}, '{16'h0009, MANT_1, OV_0_M1},
    '{16'h0002, MANT_8, OV_1_M8}, '{16'h001a, MANT_4, OV_1_M4},
    '{16'h0003, MANT_2, OV_1_M2}, '{16'h800b, MANT_1, OV_1_M1}};
  always #25 clk = ~clk;
  host_model host (.clk(clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));
  bus_address_and_vout_reset_config dut (.clk(clk), .nrst(nrst), .req(req),
    .restore(restore), .stored_cfg(stored_cfg), .stored_addr(stored_addr),
    .strap_addr(7'h00), .strap_external_divider_select(external_divider_select), .strap_primary(prim),
    .output_reset_pin(pin), .scale_mantissa(mant), .rd_data(rd_data),
    .rd_valid(rd_valid), .respond_addr(respond_addr), .strap_base(strap_base),
    .save_cfg(save_cfg), .save_addr(save_addr), .save_strobe(save_strobe),
    .boot_transition(boot), .cfg_out(co));
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // read with bounded wait, compared against expectation
  task automatic read_check(input logic [7:0] cmd, input logic [15:0] exp);
    host.rd(cmd, d, ok);
    if (!ok)
    begin
      n_errors++;
      test_done();
    end
    check("read", d, exp);
  endtask
  // one restore pulse loading the stored image
  task automatic do_restore(input logic [6:0] a, input logic [15:0] c);
    @(posedge clk)
    begin
      stored_addr <= a;
      stored_cfg <= c;
      restore <= 1'b1;
    end
    @(posedge clk) restore <= 1'b0;
    #1;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    check("rst_ov", 16'(co.ov_mv), 16'h0000);
    check("rst_boot", 16'(boot), 16'h0000);
    @(posedge clk) nrst <= 1'b1;
    // table of config writes and derived thresholds
    foreach (rows[i])
    begin
      @(posedge clk) mant <= rows[i].m;
      host.wr(CMD_RESET_PIN_OV, rows[i].w);
      read_check(CMD_RESET_PIN_OV, {11'h000, external_divider_select, rows[i].w[3:0]});
      check("ov", 16'(co.ov_mv), 16'(rows[i].ov));
      check("ov_en", {15'h0000, co.ov_enable}, {15'h0000, ~rows[i].w[0]});
      check("hi", 16'(co.reset_high_mv),
        16'(rows[i].w[3] ? RST_HI_HIGH_SEL : RST_HI_LOW_SEL));
      check("lo", 16'(co.reset_low_mv),
        16'(rows[i].w[3] ? RST_LO_HIGH_SEL : RST_LO_LOW_SEL));
    end
    // reset pin low while disabled, then enable while low
    @(posedge clk) pin <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check("boot_off", 16'(boot), 16'h0000);
    host.wr(CMD_RESET_PIN_OV, 16'h0004);
    #1 check("boot_now", 16'(boot), 16'h0001);
    check("rst_en", 16'(co.reset_enable), 16'h0001);
    @(posedge clk) pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("boot_rel", 16'(boot), 16'h0000);
    @(posedge clk) pin <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check("boot_low", 16'(boot), 16'h0001);
    // address write, store, then supply reset
    host.wr(CMD_BUS_ADDRESS, 16'hffff);
    read_check(CMD_BUS_ADDRESS, 16'h7f7f);
    check("addr_hold", 16'(respond_addr), 16'h0000);
    host.wr(CMD_STORE_ALL, 16'h0000);
    #1 check("store", {save_strobe, save_addr[14:0]}, 16'hff7f);
    check("save_cfg", save_cfg, 16'h7f04);
    check("store_hold", 16'(respond_addr), 16'h0000);
    do_restore(7'h15, 16'h2201);
    check("resp", 16'(respond_addr), 16'h0015);
    check("base", 16'(strap_base), 16'h0015);
    read_check(CMD_BUS_ADDRESS, 16'h1522);
    read_check(CMD_RESET_PIN_OV, 16'h0011);
    do_restore(7'h6f, 16'h0000);
    check("base_top", 16'(strap_base), 16'h006f);
    do_restore(7'h71, 16'h0000);
    check("base_clamp", 16'(strap_base), 16'h0070);
    @(posedge clk) prim <= 1'b1;
    do_restore(7'h15, 16'h2200);
    read_check(CMD_BUS_ADDRESS, 16'h1515);
    host.wr(CMD_BUS_ADDRESS, 16'h2a55);
    read_check(CMD_BUS_ADDRESS, 16'h2a2a);
    // divider strap low, write to its bit must not stick
    @(posedge clk) external_divider_select <= 1'b0;
    host.wr(CMD_RESET_PIN_OV, 16'h0010);
    read_check(CMD_RESET_PIN_OV, 16'h0000);
    read_check(8'hd4, 16'h0000);
    test_done();
  end
endmodule // tb_top
